// ==== srsdp_chk.sv ====
// Concurrent checks on the ports of the serial peripheral port block.
module srsdp_chk (
   input wire I_MCLK,
   input wire I_RST,
   input wire [7:0] I_ADDR,
   input wire [7:0] I_WDATA,
   input wire I_WR,
   input wire I_RD,
   input wire [7:0] O_RDATA,
   input wire [7:0] I_PIN,
   input wire [7:0] O_PIN,
   input wire [7:0] O_PIN_OE,
   input wire I_RX_TWO_WIRE,
   input wire I_TX_TWO_WIRE,
   input wire [1:0] I_ASYNC_TXD
);
   default clocking cb @(posedge I_MCLK);
   endclocking
   default disable iff (I_RST);
   logic [2:0] rate_sh;
   logic [8:0] hi_cnt;
   logic st_rd;
   logic fault_seen;
   // ------------
   // Helper state
   // ------------
   // Shadow rate code, length of the shift clock high phase, and a fault seen by software.
   always @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         rate_sh <= 3'h0;
         hi_cnt <= 9'h000;
         st_rd <= 1'b0;
         fault_seen <= 1'b0;
      end else begin
         if (I_WR && I_ADDR == 8'hd2) begin
            rate_sh <= I_WDATA[2:0];
         end
         hi_cnt <= (O_PIN[6] && O_PIN_OE[6]) ? hi_cnt + 9'h001 : 9'h000;
         st_rd <= I_RD && I_ADDR == 8'hd3;
         if (I_WR && I_ADDR == 8'hd0) begin
            fault_seen <= 1'b0;
         end else if (st_rd && O_RDATA[4]) begin
            fault_seen <= 1'b1;
         end
      end
   end
   // ------------
   // Assertions
   // ------------
   rate_rdbk_a: assert property (
      I_WR && I_ADDR == 8'hd2 ##1 I_RD && I_ADDR == 8'hd2
      |=> O_RDATA == {5'h00, $past(I_WDATA[2:0], 2)}) else $error("Rate read-back wrong.");
   dir_rdbk_a: assert property (
      I_WR && I_ADDR == 8'hd7 ##1 I_RD && I_ADDR == 8'hd7
      |=> O_RDATA[4:0] == $past(I_WDATA[4:0], 2)) else $error("Direction read-back wrong.");
   status_rsvd_a: assert property (
      I_RD && I_ADDR == 8'hd3 |=> (O_RDATA & 8'h2f) == 8'h00)
      else $error("Reserved status bits set.");
   sck_rate_a: assert property (
      $fell(O_PIN[6]) && O_PIN_OE[6] |-> hi_cnt == (9'h001 << rate_sh))
      else $error("Shift clock high phase has the wrong length.");
   mosi_hold_a: assert property (
      O_PIN[6] && $past(O_PIN[6]) && O_PIN_OE[5] |-> $stable(O_PIN[5]))
      else $error("Data out moved while shift clock high.");
   rx_input_a: assert property (
      I_RX_TWO_WIRE && $past(I_RX_TWO_WIRE) |-> !O_PIN_OE[2] && !O_PIN_OE[0])
      else $error("Receiver pin driven.");
   tx_output_a: assert property (
      I_TX_TWO_WIRE && $past(I_TX_TWO_WIRE) && !$past(I_RST) && !$past(I_RST, 2)
      |-> O_PIN_OE[3] && O_PIN_OE[1]) else $error("Transmitter pin not driven.");
   fault_ctl_a: assert property (
      fault_seen && I_RD && I_ADDR == 8'hd0 |=> O_RDATA[6] == 1'b0 && O_RDATA[4] == 1'b0)
      else $error("Control bits visible during fault.");
   reset_hiz_a: assert property (@(posedge I_MCLK) disable iff (1'b0)
      I_RST && $past(I_RST) |-> O_PIN_OE == 8'h00 && O_RDATA == 8'h00)
      else $error("Pins driven in reset.");
   // Main scenarios reached.
   cover property (I_RD && I_ADDR == 8'hd3 ##1 O_RDATA[7]);
   cover property (I_RD && I_ADDR == 8'hd3 ##1 O_RDATA[6]);
   cover property (fault_seen && I_WR && I_ADDR == 8'hd0);
endmodule // srsdp_chk

bind srsdp_top srsdp_chk srsdp_chk_inst (.I_MCLK(I_MCLK), .I_RST(I_RST), .I_ADDR(I_ADDR),
   .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_PIN(I_PIN),
   .O_PIN(O_PIN), .O_PIN_OE(O_PIN_OE), .I_RX_TWO_WIRE(I_RX_TWO_WIRE),
   .I_TX_TWO_WIRE(I_TX_TWO_WIRE), .I_ASYNC_TXD(I_ASYNC_TXD));

// ==== srsdp_peer.sv ====
// Behavioural remote slave that swaps one byte per select window.
module srsdp_peer (
   input wire i_sck,
   input wire i_sel_n,
   input wire i_mosi,
   input wire [7:0] i_load,
   output wire o_miso,
   output logic [7:0] o_got
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] sh = 8'h00;
   logic smp = 1'b0;
   logic lst = 1'b0;
   // Load on select, sample on the rising shift clock, move on the falling one.
   always @(negedge i_sel_n) sh = i_load;
   // The shift clock idles low outside frames, so its edges need no select qualifier.
   // The last falling edge and the rising select share a time step, so the received
   // byte is kept at every shift rather than at the close of the window.
   always @(posedge i_sck) smp = i_mosi;
   always @(negedge i_sck) begin
      sh = {sh[6:0], smp};
      o_got = sh;
      lst = sh[7];
   end
   // A released line shows the inverse of its last bit, so a stale copy is never read.
   assign o_miso = i_sel_n ? ~lst : sh[7];
endmodule // srsdp_peer

// ==== srsdp_regs.vh ====
// Register offsets, field positions, reset values and counts of the serial port block.
`ifndef SRSDP_REGS_VH
`define SRSDP_REGS_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define SRSDP_OFS_CONTROL   8'hd0
`define SRSDP_OFS_RATE      8'hd2
`define SRSDP_OFS_STATUS    8'hd3
`define SRSDP_OFS_DATA      8'hd5
`define SRSDP_OFS_PORT      8'hd6
`define SRSDP_OFS_DIR       8'hd7

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SRSDP_CTL_ENABLE    6
`define SRSDP_CTL_MASTER    4
`define SRSDP_CTL_SSOE      1
`define SRSDP_ST_DONE       7
`define SRSDP_ST_COLL       6
`define SRSDP_ST_FAULT      4
`define SRSDP_PIN_SEL       7
`define SRSDP_PIN_SCK       6
`define SRSDP_PIN_MOSI      5
`define SRSDP_PIN_MISO      4
`define SRSDP_PIN_TX1       3
`define SRSDP_PIN_RX1       2
`define SRSDP_PIN_TX0       1
`define SRSDP_PIN_RX0       0

// ----------------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------------
`define SRSDP_RST_BYTE      8'h00
`define SRSDP_RST_RATE      3'h0
`define SRSDP_RST_CNT       3'h0
`define SRSDP_LAST_BIT      3'h7
`define SRSDP_ONE_TICK      8'h01
`define SRSDP_RST_TICK      8'h00

`endif

// ==== srsdp_top.v ====
// Serial peripheral port: rate select, status flags, data shifter and shared port pins.
//
// Local design decision: strobed register access.
`include "srsdp_regs.vh"

// What this block does
// - Rate code 0..7 divides the bus clock by 2,4,8,...,256 for the shift clock.
// - Rate register resets to zero; its upper five bits read zero.
// - Status readable anytime, writes ignored, bits 5 and 3..0 read zero.
// - Transfer-complete flag (bit 7) sets after the eighth shift clock cycle.
// - Status read seeing transfer-complete, then data access, clears it.
// - Data write during transfer is dropped and sets collision flag bit 6, no interrupt.
// - Status read seeing collision, then data access, clears collision flag.
// - Master mode with select input low sets mode-fault flag bit 4.
// - Direction bit 7 set suppresses mode-fault detection; the flag stays clear.
// - Status read seeing mode fault, then control write, clears mode-fault flag.
// - Data reads give buffered received byte; writes load shifter; reset keeps contents.
// - Master and slave bytes form a 16-bit ring shifted eight places.
// - After reset all eight pins are inputs with direction cleared.
// - Port read gives pin level for inputs, driver value for outputs.
// - Port latch drives only general-purpose outputs, never serial-function outputs.
// - Direction bit 0 is input, 1 is output; readable and writable anytime.
// - Receiver two-wire setup forces pins 2 and 0 to inputs.
// - Transmitter two-wire setup forces pins 3 and 1 to outputs.
// - Enabled interface: its inputs are inputs; its outputs drive only with direction set.
// - Slave mode ignores direction bit 7; master uses it for fault input or output.
// - A mode fault forces direction bits 5, 6 and 7 to zero.
// - Rate divider runs only in master mode during a transfer.
// - While mode fault is set, enable and master bits read zero.
// - Slave drives data out only with direction bit 4 set, select low, slave mode.
module srsdp_top (
   input wire I_MCLK,
   input wire I_RST,
   input wire [7:0] I_ADDR,
   input wire [7:0] I_WDATA,
   input wire I_WR,
   input wire I_RD,
   output reg [7:0] O_RDATA,
   input wire [7:0] I_PIN,
   output reg [7:0] O_PIN,
   output reg [7:0] O_PIN_OE,
   input wire I_RX_TWO_WIRE,
   input wire I_TX_TWO_WIRE,
   input wire [1:0] I_ASYNC_TXD
);

   // -------------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------------
   reg [7:0] pin_meta;
   reg [7:0] pin_sync;
   reg sck_last;
   reg [2:0] rate_code;
   reg ctl_enable;
   reg ctl_master;
   reg ctl_ssoe;
   reg [7:0] dir;
   reg [7:0] port_latch;
   reg [7:0] rx_buf;
   reg done_flag;
   reg coll_flag;
   reg fault_flag;
   reg seen_done;
   reg seen_coll;
   reg seen_fault;
   reg [7:0] shifter;
   reg rx_bit;
   reg [2:0] bit_cnt;
   reg busy;
   reg sck_out;
   reg [7:0] tick_cnt;
   reg [7:0] next_pin;
   reg [7:0] next_oe;
   reg [7:0] next_rdata;
   wire eff_enable;
   wire eff_master;
   wire slave_on;
   wire sel_in;
   wire sck_rise;
   wire sck_fall;
   wire [7:0] half_lim;
   wire tick;
   wire [7:0] shifted;
   wire hit_wr_data;
   wire data_access;
   wire ctl_write;
   wire stat_read;
   wire master_start;
   wire xfer_busy;
   wire coll_evt;
   wire fault_evt;
   wire done_evt;
   wire master_tick_rise;
   wire master_tick_fall;

   // -------------------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------------------

   // Pins come from outside; two flops before any logic, third flop for edges.
   always @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         pin_meta <= `SRSDP_RST_BYTE;
         pin_sync <= `SRSDP_RST_BYTE;
         sck_last <= 1'b0;
      end else begin
         pin_meta <= I_PIN;
         pin_sync <= pin_meta;
         sck_last <= pin_sync[`SRSDP_PIN_SCK];
      end
   end

   // -------------------------------------------------------------------------
   // Decode and mode
   // -------------------------------------------------------------------------

   // A pending mode fault takes the interface out of master operation.
   assign eff_enable = ctl_enable & ~fault_flag;
   assign eff_master = ctl_master & ~fault_flag;
   assign slave_on = eff_enable & ~eff_master;
   assign sel_in = pin_sync[`SRSDP_PIN_SEL];
   assign sck_rise = pin_sync[`SRSDP_PIN_SCK] & ~sck_last;
   assign sck_fall = ~pin_sync[`SRSDP_PIN_SCK] & sck_last;
   assign stat_read = I_RD & (I_ADDR == `SRSDP_OFS_STATUS);
   assign data_access = (I_RD | I_WR) & (I_ADDR == `SRSDP_OFS_DATA);
   assign hit_wr_data = I_WR & (I_ADDR == `SRSDP_OFS_DATA);
   assign ctl_write = I_WR & (I_ADDR == `SRSDP_OFS_CONTROL);

   // A slave counts as busy for the whole time it is selected.
   assign xfer_busy = busy | (slave_on & ~sel_in);
   assign coll_evt = hit_wr_data & xfer_busy;
   assign master_start = hit_wr_data & ~xfer_busy & eff_enable & eff_master;

   // Fault input only exists while direction bit 7 is clear.
   assign fault_evt = eff_enable & eff_master & ~dir[`SRSDP_PIN_SEL] & ~sel_in;

   // -------------------------------------------------------------------------
   // Rate divider
   // -------------------------------------------------------------------------

   // Half the divisor: toggling every half_lim+1 cycles gives bus clock / 2^(code+1).
   assign half_lim = (`SRSDP_ONE_TICK << rate_code) - `SRSDP_ONE_TICK;
   assign tick = busy & eff_master & (tick_cnt == half_lim);
   assign master_tick_rise = tick & ~sck_out;
   assign master_tick_fall = tick & sck_out;
   assign shifted = {shifter[6:0], rx_bit};
   assign done_evt = (master_tick_fall | (slave_on & ~sel_in & sck_fall))
                     & (bit_cnt == `SRSDP_LAST_BIT);

   // -------------------------------------------------------------------------
   // Shift engine
   // -------------------------------------------------------------------------

   // Clock idles low; bits are sampled on the rising edge and shifted on the falling one.
   // The divider counter stays cleared unless a master transfer is running.
   always @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         shifter <= `SRSDP_RST_BYTE;
         rx_bit <= 1'b0;
         bit_cnt <= `SRSDP_RST_CNT;
         busy <= 1'b0;
         sck_out <= 1'b0;
         tick_cnt <= `SRSDP_RST_TICK;
      end else begin
         if (hit_wr_data & ~xfer_busy) begin
            shifter <= I_WDATA;
         end
         if (!eff_enable) begin
            busy <= 1'b0;
            sck_out <= 1'b0;
            bit_cnt <= `SRSDP_RST_CNT;
            tick_cnt <= `SRSDP_RST_TICK;
         end else if (eff_master) begin
            if (master_start) begin
               busy <= 1'b1;
               sck_out <= 1'b0;
               bit_cnt <= `SRSDP_RST_CNT;
               tick_cnt <= `SRSDP_RST_TICK;
            end else if (busy) begin
               if (tick) begin
                  tick_cnt <= `SRSDP_RST_TICK;
                  sck_out <= ~sck_out;
               end else begin
                  tick_cnt <= tick_cnt + `SRSDP_ONE_TICK;
               end
               if (master_tick_rise) begin
                  rx_bit <= pin_sync[`SRSDP_PIN_MISO];
               end
               if (master_tick_fall) begin
                  shifter <= shifted;
                  bit_cnt <= bit_cnt + 3'h1;
                  if (bit_cnt == `SRSDP_LAST_BIT) begin
                     busy <= 1'b0;
                  end
               end
            end else begin
               tick_cnt <= `SRSDP_RST_TICK;
            end
         end else begin
            // Slave: the remote master's clock steps the same ring.
            busy <= 1'b0;
            tick_cnt <= `SRSDP_RST_TICK;
            if (sel_in) begin
               bit_cnt <= `SRSDP_RST_CNT;
            end else begin
               if (sck_rise) begin
                  rx_bit <= pin_sync[`SRSDP_PIN_MOSI];
               end
               if (sck_fall) begin
                  shifter <= shifted;
                  bit_cnt <= bit_cnt + 3'h1;
               end
            end
         end
      end
   end

   // -------------------------------------------------------------------------
   // Receive buffer and port latch
   // -------------------------------------------------------------------------

   // No reset here on purpose: both keep their contents across a reset.
   always @(posedge I_MCLK) begin
      if (done_evt) begin
         rx_buf <= shifted;
      end
      if (I_WR & (I_ADDR == `SRSDP_OFS_PORT)) begin
         port_latch <= I_WDATA;
      end
   end

   // -------------------------------------------------------------------------
   // Control, rate and direction registers
   // -------------------------------------------------------------------------

   // Fault forcing of direction bits wins over a same-cycle software write.
   always @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         rate_code <= `SRSDP_RST_RATE;
         ctl_enable <= 1'b0;
         ctl_master <= 1'b0;
         ctl_ssoe <= 1'b0;
         dir <= `SRSDP_RST_BYTE;
      end else begin
         if (I_WR & (I_ADDR == `SRSDP_OFS_RATE)) begin
            rate_code <= I_WDATA[2:0];
         end
         if (ctl_write) begin
            ctl_enable <= I_WDATA[`SRSDP_CTL_ENABLE];
            ctl_master <= I_WDATA[`SRSDP_CTL_MASTER];
            ctl_ssoe <= I_WDATA[`SRSDP_CTL_SSOE];
         end
         if (I_WR & (I_ADDR == `SRSDP_OFS_DIR)) begin
            dir <= I_WDATA;
         end
         if (fault_evt) begin
            dir[7:5] <= 3'h0;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Status flags
   // -------------------------------------------------------------------------

   // A status read records which flags it saw; the following access clears
   // only those, and a set in the same cycle is never lost.
   always @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         done_flag <= 1'b0;
         coll_flag <= 1'b0;
         fault_flag <= 1'b0;
         seen_done <= 1'b0;
         seen_coll <= 1'b0;
         seen_fault <= 1'b0;
      end else begin
         done_flag <= done_evt | (done_flag & ~(data_access & seen_done));
         coll_flag <= coll_evt | (coll_flag & ~(data_access & seen_coll));
         fault_flag <= fault_evt | (fault_flag & ~(ctl_write & seen_fault));
         if (stat_read) begin
            seen_done <= done_flag;
            seen_coll <= coll_flag;
            seen_fault <= fault_flag;
         end else begin
            if (data_access) begin
               seen_done <= 1'b0;
               seen_coll <= 1'b0;
            end
            if (ctl_write) begin
               seen_fault <= 1'b0;
            end
         end
      end
   end

   // -------------------------------------------------------------------------
   // Pin drivers
   // -------------------------------------------------------------------------

   // Serial functions override the port latch; direction bits gate the drivers except pins 3 and 1 under transmitter two-wire setup.
   always @* begin
      next_pin = port_latch;
      next_oe = dir;
      if (I_RX_TWO_WIRE) begin
         next_oe[`SRSDP_PIN_RX0] = 1'b0;
         next_oe[`SRSDP_PIN_RX1] = 1'b0;
      end
      if (I_TX_TWO_WIRE) begin
         next_oe[`SRSDP_PIN_TX0] = 1'b1;
         next_oe[`SRSDP_PIN_TX1] = 1'b1;
         next_pin[`SRSDP_PIN_TX0] = I_ASYNC_TXD[0];
         next_pin[`SRSDP_PIN_TX1] = I_ASYNC_TXD[1];
      end
      if (eff_enable) begin
         if (eff_master) begin
            next_oe[`SRSDP_PIN_MISO] = 1'b0;
            next_pin[`SRSDP_PIN_MOSI] = shifter[7];
            next_pin[`SRSDP_PIN_SCK] = sck_out;
            if (dir[`SRSDP_PIN_SEL] & ctl_ssoe) begin
               next_pin[`SRSDP_PIN_SEL] = ~busy;
            end
         end else begin
            next_oe[`SRSDP_PIN_MOSI] = 1'b0;
            next_oe[`SRSDP_PIN_SCK] = 1'b0;
            next_oe[`SRSDP_PIN_SEL] = 1'b0;
            next_oe[`SRSDP_PIN_MISO] = dir[`SRSDP_PIN_MISO] & ~sel_in;
            next_pin[`SRSDP_PIN_MISO] = shifter[7];
         end
      end
   end

   // Registered so every pin output comes straight from a flop.
   always @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         O_PIN <= `SRSDP_RST_BYTE;
         O_PIN_OE <= `SRSDP_RST_BYTE;
      end else begin
         O_PIN <= next_pin;
         O_PIN_OE <= next_oe;
      end
   end

   // -------------------------------------------------------------------------
   // Read port
   // -------------------------------------------------------------------------

   // Read data appears one cycle after the strobe and only then; unmapped reads give zero.
   always @* begin
      next_rdata = `SRSDP_RST_BYTE;
      if (I_RD) begin
         case (I_ADDR)
            `SRSDP_OFS_CONTROL: begin
               next_rdata[`SRSDP_CTL_ENABLE] = eff_enable;
               next_rdata[`SRSDP_CTL_MASTER] = eff_master;
               next_rdata[`SRSDP_CTL_SSOE] = ctl_ssoe;
            end
            `SRSDP_OFS_RATE: begin
               next_rdata = {5'h00, rate_code};
            end
            `SRSDP_OFS_STATUS: begin
               next_rdata[`SRSDP_ST_DONE] = done_flag;
               next_rdata[`SRSDP_ST_COLL] = coll_flag;
               next_rdata[`SRSDP_ST_FAULT] = fault_flag;
            end
            `SRSDP_OFS_DATA: begin
               next_rdata = rx_buf;
            end
            `SRSDP_OFS_PORT: begin
               next_rdata = (O_PIN_OE & O_PIN) | (~O_PIN_OE & pin_sync);
            end
            `SRSDP_OFS_DIR: begin
               next_rdata = dir;
            end
            default: begin
               next_rdata = `SRSDP_RST_BYTE;
            end
         endcase
      end
   end

   always @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         O_RDATA <= `SRSDP_RST_BYTE;
      end else begin
         O_RDATA <= next_rdata;
      end
   end

endmodule // srsdp_top

// ==== tb.sv ====
// Self-checking bench of the serial peripheral port block with a remote slave.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ------------
   // Signals
   // ------------
   localparam logic [7:0] A_CT = 8'hd0;
   localparam logic [7:0] A_RT = 8'hd2;
   localparam logic [7:0] A_ST = 8'hd3;
   localparam logic [7:0] A_DT = 8'hd5;
   localparam logic [7:0] A_PT = 8'hd6;
   localparam logic [7:0] A_DR = 8'hd7;
   logic I_MCLK = 1'b0;
   logic I_RST = 1'b1;
   logic [7:0] I_ADDR = 8'h00;
   logic [7:0] I_WDATA = 8'h00;
   logic I_WR = 1'b0;
   logic I_RD = 1'b0;
   logic I_RX_TWO_WIRE = 1'b0;
   logic I_TX_TWO_WIRE = 1'b0;
   logic [1:0] I_ASYNC_TXD = 2'h0;
   logic sel_drv = 1'b1;
   logic [7:0] peer_load = 8'h00;
   logic [7:0] rv;
   int n_mismatch = 0;
   int checks_done = 0;
   wire [7:0] O_RDATA;
   wire [7:0] O_PIN;
   wire [7:0] O_PIN_OE;
   wire [7:0] peer_got;
   wire peer_miso;
   // Free pins sit on pull-ups; bit 7 follows the bench and bit 4 the peer.
   wire [7:0] ext_lvl = {sel_drv, 2'h3, peer_miso, 4'hf};
   wire [7:0] I_PIN = (O_PIN_OE & O_PIN) | (~O_PIN_OE & ext_lvl);
   // Bus clock at 125 MHz.
   always #4 I_MCLK = ~I_MCLK;
   srsdp_top srsdp_top_inst (.I_MCLK(I_MCLK), .I_RST(I_RST), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
      .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_PIN(I_PIN), .O_PIN(O_PIN),
      .O_PIN_OE(O_PIN_OE), .I_RX_TWO_WIRE(I_RX_TWO_WIRE), .I_TX_TWO_WIRE(I_TX_TWO_WIRE),
      .I_ASYNC_TXD(I_ASYNC_TXD));
   srsdp_peer srsdp_peer_inst (.i_sck(I_PIN[6]), .i_sel_n(I_PIN[7]), .i_mosi(I_PIN[5]),
      .i_load(peer_load), .o_miso(peer_miso), .o_got(peer_got));
   // ------------
   // Bus tasks
   // ------------
   // Every bus change lands just after a rising edge; a strobe stands one cycle.
   task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
      @(posedge I_MCLK);
      I_WR <= w;
      I_RD <= r;
      I_ADDR <= a;
      I_WDATA <= d;
   endtask
   task automatic cyc(input int n);
      repeat (n) bus(1'b0, 1'b0, 8'h00, 8'h00);
   endtask
   task automatic step;
      cyc(1);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, 1'b0, a, d);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      bus(1'b0, 1'b1, a, 8'h00);
      step;
      d = O_RDATA;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
      rd(a, rv);
      chk(rv, exp);
   endtask
   // Polls status with a bound; a hang here counts as a mismatch.
   task automatic wait_done;
      for (int i = 0; i < 3000; i++) begin
         rd(A_ST, rv);
         if (rv[7] === 1'b1) return;
      end
      chk(rv, 8'h80);
   endtask
   // ------------
   // Scenarios
   // ------------
   task automatic t_reset;
      chk(O_PIN_OE, 8'h00);
      chk_rd(A_RT, 8'h00);
      chk_rd(A_ST, 8'h00);
      chk_rd(A_DR, 8'h00);
      $display("test reset done");
   endtask
   task automatic t_regs;
      wr(A_RT, 8'hff);
      chk_rd(A_RT, 8'h07);
      wr(A_ST, 8'hff);
      chk_rd(A_ST, 8'h00);
      wr(A_DR, 8'h0f);
      chk_rd(A_DR, 8'h0f);
      chk_rd(8'h40, 8'h00);
      $display("test regs done");
   endtask
   task automatic t_port;
      wr(A_PT, 8'ha5);
      cyc(4);
      #1;
      chk(O_PIN_OE, 8'h0f);
      chk(O_PIN & 8'h0f, 8'h05);
      chk_rd(A_PT, 8'hf5);
      cyc(1);
      I_RX_TWO_WIRE <= 1'b1;
      I_TX_TWO_WIRE <= 1'b1;
      I_ASYNC_TXD <= 2'h3;
      cyc(4);
      #1;
      chk(O_PIN_OE & 8'h0f, 8'h0a);
      chk(O_PIN & 8'h0a, 8'h0a);
      cyc(1);
      I_RX_TWO_WIRE <= 1'b0;
      I_TX_TWO_WIRE <= 1'b0;
      $display("test port done");
   endtask
   task automatic t_rates;
      int hi;
      wr(A_DR, 8'he0);
      wr(A_CT, 8'h52);
      for (int c = 0; c < 8; c++) begin
         wr(A_RT, 8'(c));
         cyc(4);
         #1;
         chk(O_PIN & 8'h40, 8'h00);
         wr(A_DT, 8'h81);
         step;
         hi = 0;
         repeat (300) if (O_PIN[6] !== 1'b1) step;
         while (O_PIN[6] === 1'b1 && hi < 300) begin
            step;
            hi++;
         end
         chk(8'(hi), 8'(1 << c));
         wait_done;
         chk(rv, 8'h80);
         rd(A_DT, rv);
         chk_rd(A_ST, 8'h00);
      end
      $display("test rates done");
   endtask
   task automatic t_xchg;
      wr(A_RT, 8'h02);
      cyc(1);
      peer_load <= 8'h3c;
      wr(A_DT, 8'ha5);
      cyc(3);
      wr(A_DT, 8'h5a);
      wait_done;
      chk(rv, 8'hc0);
      chk_rd(A_DT, 8'h3c);
      chk(peer_got, 8'ha5);
      chk_rd(A_ST, 8'h00);
      wr(A_DT, 8'h11);
      cyc(100);
      rd(A_DT, rv);
      chk_rd(A_ST, 8'h80);
      rd(A_DT, rv);
      $display("test exchange done");
   endtask
   task automatic t_fault;
      wr(A_CT, 8'h00);
      wr(A_DR, 8'h60);
      wr(A_CT, 8'h50);
      cyc(1);
      sel_drv <= 1'b0;
      cyc(6);
      chk_rd(A_ST, 8'h10);
      chk_rd(A_CT, 8'h00);
      chk_rd(A_DR, 8'h00);
      chk_rd(A_ST, 8'h10);
      wr(A_CT, 8'h00);
      chk_rd(A_ST, 8'h00);
      wr(A_DR, 8'h80);
      wr(A_CT, 8'h50);
      cyc(6);
      chk_rd(A_ST, 8'h00);
      chk(O_PIN_OE & 8'hf0, 8'h80);
      wr(A_CT, 8'h40);
      wr(A_DR, 8'h90);
      cyc(6);
      #1;
      chk(O_PIN_OE & 8'hf0, 8'h10);
      cyc(1);
      sel_drv <= 1'b1;
      cyc(6);
      #1;
      chk(O_PIN_OE & 8'hf0, 8'h00);
      wr(A_CT, 8'h00);
      cyc(1);
      $display("test fault done");
   endtask
   // ------------
   // Sequence and verdict
   // ------------
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge I_MCLK);
      I_RST <= 1'b0;
      cyc(2);
      t_reset;
      t_regs;
      t_port;
      t_rates;
      t_xchg;
      t_fault;
      wrap_up;
   end
   // Whole run needs about 4500 cycles; the 30000-cycle limit means a hang.
   initial begin
      repeat (30000) @(posedge I_MCLK);
      n_mismatch++;
      wrap_up;
   end
endmodule // tb
